// [rtl/dcap_cap.sv]
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dcap_cap
    import dcap_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC // Start-up wait in clocks
) (
    input wire logic clk_i, // System clock
    input wire logic rstn_i, // Synchronous reset, active low
    input wire logic ce_i, // Clock enable
    input wire logic [7:0] addr_i, // Register byte address
    input wire logic [31:0] wdata_i, // Write data
    input wire logic we_i, // Write strobe
    input wire logic re_i, // Read strobe
    output logic [31:0] rdata_o, // Read data, cycle after re_i
    output logic irq_o, // Interrupt level
    dcap_if.cap link // Port toward the converter
);

    localparam int SW = 2 * W + 3; // Synchronised pin bundle width

    logic [SW-1:0] in_s1_q; // First stage, read only by second
    logic [SW-1:0] in_s2_q; // {strb a, strb b, ovr, a, b}
    logic sa_s3_q; // Delayed A strobe for edges
    logic sb_s3_q; // Delayed B strobe for edges
    logic fall_a; // A strobe falling
    logic fall_b; // B strobe falling
    logic gate_en_q; // Software gate request
    logic gate_q; // Gate pin flop
    logic [3:0] glow_q; // Low-time counter on gate
    logic [7:0] rcnt_q; // Reset pulse counter
    logic rst_n_q; // Reset pin flop
    logic [31:0] boot_q; // Start-up counter
    logic ready_q; // Converter output trusted
    logic [BUF_AW-1:0] wpa_q; // Buffer A write slot
    logic [BUF_AW-1:0] wpb_q; // Buffer B write slot
    logic [W-1:0] buf_a [BUF_DEPTH]; // Channel A buffer
    logic [W-1:0] buf_b [BUF_DEPTH]; // Channel B buffer
    logic [NSTAT-1:0] stat_q; // Sticky events
    logic [NSTAT-1:0] stat_d; // Next sticky events
    logic [NSTAT-1:0] stat_set; // Events this cycle
    logic [NSTAT-1:0] mask_q; // Interrupt mask
    logic rdy_rise; // Start-up just ended
    logic wr_cmd_rst; // Reset command write

    // Converter pins: two flops before use
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            in_s1_q <= '0;
            in_s2_q <= '0;
            sa_s3_q <= 1'b0;
            sb_s3_q <= 1'b0;
        end else if (ce_i) begin
            in_s1_q <= {link.chan_a_strobe_t, link.chan_b_strobe_t, link.overrange_flag_t,
                        link.chan_a_word_t, link.chan_b_word_t};
            in_s2_q <= in_s1_q;
            sa_s3_q <= in_s2_q[SW-1];
            sb_s3_q <= in_s2_q[SW-2];
        end
    end

    // Capture on strobe fall, mid-period, where words are steady
    assign fall_a = sa_s3_q && !in_s2_q[SW-1] && ready_q;
    assign fall_b = sb_s3_q && !in_s2_q[SW-2] && ready_q;

    // Gate pin; once low it stays low a minimum time
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            gate_q <= 1'b1;
            glow_q <= '0;
        end else if (ce_i) begin
            if (!gate_q && glow_q < 4'(GATE_MIN_CYC)) begin // Hold low
                glow_q <= glow_q + 4'h1;
            end else begin // Follow software, aligning collection
                gate_q <= gate_en_q;
                glow_q <= '0;
            end
        end
    end

    // Reset pulse to the converter
    assign wr_cmd_rst = we_i && (addr_i == REG_CMD) && wdata_i[CMD_RST_BIT];
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rcnt_q <= '0;
            rst_n_q <= 1'b1;
        end else if (ce_i) begin
            if (wr_cmd_rst) begin // Start a full-length pulse
                rcnt_q <= 8'(RST_MIN_CYC);
                rst_n_q <= 1'b0;
            end else if (rcnt_q != 8'h0) begin
                rcnt_q <= rcnt_q - 8'h1;
                rst_n_q <= (rcnt_q == 8'h1);
            end
        end
    end

    // Outputs ignored until start-up time after any reset
    always_ff @(posedge clk_i) begin
        if (!rstn_i || !rst_n_q) begin
            boot_q <= '0;
            ready_q <= 1'b0;
        end else if (ce_i && !ready_q) begin
            boot_q <= boot_q + 32'h1;
            ready_q <= (boot_q == 32'(STARTUP_CYCLES - 1));
        end
    end
    assign rdy_rise = ce_i && !ready_q && rst_n_q && (boot_q == 32'(STARTUP_CYCLES - 1));

    // Buffers written by each channel's own strobe
    // Lost samples leave no gap marker; pointers just stop
    always_ff @(posedge clk_i) begin
        if (ce_i && fall_a) begin
            buf_a[wpa_q] <= in_s2_q[2*W-1:W];
        end
        if (ce_i && fall_b) begin
            buf_b[wpb_q] <= in_s2_q[W-1:0];
        end
    end

    // Write pointers
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            wpa_q <= '0;
            wpb_q <= '0;
        end else if (ce_i) begin
            if (fall_a) begin
                wpa_q <= wpa_q + 4'h1;
            end
            if (fall_b) begin
                wpb_q <= wpb_q + 4'h1;
            end
        end
    end

    // Sticky status; a new event wins over a clear
    always_comb begin
        stat_set = '0;
        stat_set[ST_CAP] = fall_a;
        stat_set[ST_OVR] = fall_a && in_s2_q[2*W];
        stat_set[ST_WRAP] = fall_a && (wpa_q == 4'hf);
        stat_set[ST_RDY] = rdy_rise;
        stat_d = stat_q;
        if (we_i && addr_i == REG_STAT) begin
            stat_d = stat_q & ~wdata_i[NSTAT-1:0];
        end
        stat_d = stat_d | stat_set;
    end

    // Software registers and interrupt
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            stat_q <= '0;
            mask_q <= '0;
            gate_en_q <= CTRL_GATE_RST;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            stat_q <= stat_d;
            irq_o <= |(stat_d & mask_q);
            if (we_i && addr_i == REG_MASK) begin
                mask_q <= wdata_i[NSTAT-1:0];
            end
            if (we_i && addr_i == REG_CTRL) begin
                gate_en_q <= wdata_i[CTRL_GATE_BIT];
            end
        end
    end

    // Read port, data one cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= '0;
            if (re_i) begin
                if (addr_i[7:6] == BUF_A_SEL) begin
                    rdata_o <= {20'h0, buf_a[addr_i[5:2]]};
                end else if (addr_i[7:6] == BUF_B_SEL) begin
                    rdata_o <= {20'h0, buf_b[addr_i[5:2]]};
                end else begin
                    case (addr_i)
                        REG_CTRL: rdata_o <= {31'h0, gate_en_q};
                        REG_STAT: rdata_o <= {28'h0, stat_q};
                        REG_MASK: rdata_o <= {28'h0, mask_q};
                        REG_INFO: rdata_o <= {22'h0, wpb_q, wpa_q, ready_q, rst_n_q};
                        default: rdata_o <= '0;
                    endcase
                end
            end
        end
    end

    assign link.strobe_gate_in = gate_q;
    assign link.dev_rst_n = rst_n_q;

endmodule : dcap_cap
`default_nettype wire

// [rtl/dcap_pkg.sv]
package dcap_pkg;
    // Base clock
    localparam int CLK_NS = 10; // Period of clk_i in ns
    // Sample pacing: one sample per SAMPLE_DIV clocks
    localparam int SAMPLE_DIV = 8;
    localparam int STB_HIGH = 4; // Strobe high clocks per sample
    localparam int PH_W = 3; // Phase counter width
    localparam logic [PH_W-1:0] PH_LAST = 3'h7;
    localparam logic [PH_W-1:0] PH_HIGH = 3'h4;
    // Pipeline depth in sample clocks
    localparam int LATENCY = 74;
    localparam int LAT_W = 7;
    localparam logic [LAT_W-1:0] LAT_LAST = 7'h49; // LATENCY - 1
    localparam logic [LAT_W-1:0] LAT_FULL = 7'h4a; // LATENCY
    // Sample coding
    localparam int W = 12;
    localparam int IN_W = 14;
    localparam logic [W-1:0] CODE_MAX = 12'h7ff;
    localparam logic [W-1:0] CODE_ZERO = 12'h000;
    localparam logic [W-1:0] CODE_MIN = 12'h800;
    localparam logic signed [IN_W-1:0] IN_MAX = 14'sh07ff;
    localparam logic signed [IN_W-1:0] IN_MIN = 14'sh3800;
    // Link timing
    localparam int RST_MIN_NS = 200;
    localparam int RST_MIN_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int GATE_MIN_NS = 5;
    localparam int GATE_MIN_CYC = (GATE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int STARTUP_MS = 600;
    localparam int STARTUP_CYC = STARTUP_MS * 1000000 / CLK_NS;
    // Controller registers
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STAT = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0c;
    localparam logic [7:0] REG_INFO = 8'h10;
    localparam logic [1:0] BUF_A_SEL = 2'h1; // Addresses 0x40..0x7c
    localparam logic [1:0] BUF_B_SEL = 2'h2; // Addresses 0x80..0xbc
    localparam int BUF_AW = 4;
    localparam int BUF_DEPTH = 16;
    localparam int CTRL_GATE_BIT = 0;
    localparam logic CTRL_GATE_RST = 1'b1;
    localparam int CMD_RST_BIT = 0;
    localparam int NSTAT = 4;
    localparam int ST_CAP = 0;
    localparam int ST_OVR = 1;
    localparam int ST_WRAP = 2;
    localparam int ST_RDY = 3;
endpackage : dcap_pkg

// [rtl/dcap_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dcap_if;
    import dcap_pkg::*;
    logic strobe_gate_in; // Gate, high lets strobes run
    logic dev_rst_n; // Device reset, active low
    logic [W-1:0] chan_a_word_t; // Channel A word, true
    logic [W-1:0] chan_a_word_c; // Channel A word, complement
    logic [W-1:0] chan_b_word_t; // Channel B word, true
    logic [W-1:0] chan_b_word_c; // Channel B word, complement
    logic chan_a_strobe_t; // Channel A strobe, true
    logic chan_a_strobe_c; // Channel A strobe, complement
    logic chan_b_strobe_t; // Channel B strobe, true
    logic chan_b_strobe_c; // Channel B strobe, complement
    logic overrange_flag_t; // Overrange, true
    logic overrange_flag_c; // Overrange, complement
    modport dev (
        input strobe_gate_in, dev_rst_n,
        output chan_a_word_t, chan_a_word_c, chan_b_word_t, chan_b_word_c,
        output chan_a_strobe_t, chan_a_strobe_c, chan_b_strobe_t, chan_b_strobe_c,
        output overrange_flag_t, overrange_flag_c
    );
    modport cap (
        output strobe_gate_in, dev_rst_n,
        input chan_a_word_t, chan_a_word_c, chan_b_word_t, chan_b_word_c,
        input chan_a_strobe_t, chan_a_strobe_c, chan_b_strobe_t, chan_b_strobe_c,
        input overrange_flag_t, overrange_flag_c
    );
endinterface : dcap_if
`default_nettype wire

// [rtl/dcap_dev.sv]
`timescale 1ns/1ps
`default_nettype none
module dcap_dev
    import dcap_pkg::*;
#(
    parameter int STARTUP_CYCLES = STARTUP_CYC // Start-up wait in clocks
) (
    input wire logic clk_i, // System clock
    input wire logic rstn_i, // Synchronous reset, active low
    input wire logic ce_i, // Clock enable, freezes all state
    input wire logic signed [IN_W-1:0] ana_a_i, // Channel A input level
    input wire logic signed [IN_W-1:0] ana_b_i, // Channel B input level
    dcap_if.dev link // Port toward capture logic
);

    // Saturating quantiser: {overrange, code}
    function automatic logic [W:0] quantise(input logic signed [IN_W-1:0] x);
        logic [W:0] r;
        r = {1'b0, x[W-1:0]};
        if (x > IN_MAX) begin // Above range, clamp to top code
            r = {1'b1, CODE_MAX};
        end else if (x < IN_MIN) begin // Below range, clamp to bottom code
            r = {1'b1, CODE_MIN};
        end
        return r;
    endfunction : quantise

    // Pin synchronisers
    logic gate_s1_q; // First stage, read only by second
    logic gate_s2_q; // Synchronised gate
    logic prst_s1_q; // First stage of reset pin
    logic prst_s2_q; // Synchronised reset pin
    logic srst; // Combined reset for the device core

    // Core state
    logic [31:0] boot_q; // Start-up counter
    logic booted_q; // Start-up finished
    logic [PH_W-1:0] phase_q; // Position inside sample period
    logic tick; // Last clock of a sample period
    logic [W:0] samp_a; // Quantised A with flag
    logic [W:0] samp_b; // Quantised B with flag
    logic [2*W:0] pipe_mem [LATENCY]; // Latency line, {ovr, a, b}
    logic [LAT_W-1:0] wptr_q; // Latency line slot
    logic [LAT_W-1:0] fill_q; // Slots written since reset
    logic full; // Slot under the pointer holds a real sample
    logic run_q; // Strobes running
    logic run_d; // Next run state
    logic [PH_W-1:0] phase_d; // Next phase
    logic stb_d; // Next strobe level

    // Output flops
    logic [W-1:0] a_t_q; // Channel A word true
    logic [W-1:0] a_c_q; // Channel A word complement
    logic [W-1:0] b_t_q; // Channel B word true
    logic [W-1:0] b_c_q; // Channel B word complement
    logic ov_t_q; // Overrange true
    logic ov_c_q; // Overrange complement
    logic stb_t_q; // Strobe true, shared by both channels
    logic stb_c_q; // Strobe complement

    // Gate and reset pins come from another domain: two flops each
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            gate_s1_q <= 1'b1;
            gate_s2_q <= 1'b1;
            prst_s1_q <= 1'b1;
            prst_s2_q <= 1'b1;
        end else if (ce_i) begin
            gate_s1_q <= link.strobe_gate_in;
            gate_s2_q <= gate_s1_q;
            prst_s1_q <= link.dev_rst_n;
            prst_s2_q <= prst_s1_q;
        end
    end

    // Reset pin acts like the local reset once synchronised
    // A pin pulse shorter than one clock may be missed here
    assign srst = !rstn_i || !prst_s2_q;

    // Start-up delay after any reset; strobes stay off meanwhile
    always_ff @(posedge clk_i) begin
        if (srst) begin
            boot_q <= 32'h0;
            booted_q <= 1'b0;
        end else if (ce_i && !booted_q) begin
            boot_q <= boot_q + 32'h1;
            if (boot_q == 32'(STARTUP_CYCLES - 1)) begin // Wait over
                booted_q <= 1'b1;
            end
        end
    end

    // Sample clock divider; the device makes the link pacing itself
    assign tick = (phase_q == PH_LAST);
    assign phase_d = tick ? '0 : phase_q + 3'h1;
    always_ff @(posedge clk_i) begin
        if (srst) begin
            phase_q <= '0;
        end else if (ce_i) begin
            phase_q <= phase_d;
        end
    end

    // Quantise both channels at the sampling edge
    assign samp_a = quantise(ana_a_i);
    assign samp_b = quantise(ana_b_i);

    // Latency line: slot is read just before it is rewritten
    // No reset on the array, so fill count masks stale slots
    always_ff @(posedge clk_i) begin
        if (ce_i && tick) begin
            pipe_mem[wptr_q] <= {samp_a[W] | samp_b[W], samp_a[W-1:0], samp_b[W-1:0]};
        end
    end

    // Line pointer and fill level
    always_ff @(posedge clk_i) begin
        if (srst) begin
            wptr_q <= '0;
            fill_q <= '0;
        end else if (ce_i && tick) begin
            wptr_q <= (wptr_q == LAT_LAST) ? '0 : wptr_q + 7'h1;
            if (!full) begin // Count until line holds 74 samples
                fill_q <= fill_q + 7'h1;
            end
        end
    end
    assign full = (fill_q == LAT_FULL);

    // Run control: stop at once on gate low, start only at period start
    // Starting only at a period boundary avoids a short first pulse
    always_comb begin
        if (tick) begin // Next cycle opens a new A pulse
            run_d = gate_s2_q && booted_q && full;
        end else begin // Mid period: only a stop is possible
            run_d = run_q && gate_s2_q;
        end
        stb_d = run_d && (phase_d < PH_HIGH);
    end

    // Run state flop
    always_ff @(posedge clk_i) begin
        if (srst) begin
            run_q <= 1'b0;
        end else if (ce_i) begin
            run_q <= run_d;
        end
    end

    // Strobe pair, both channels in step
    always_ff @(posedge clk_i) begin
        if (srst) begin
            stb_t_q <= 1'b0;
            stb_c_q <= 1'b1;
        end else if (ce_i) begin
            stb_t_q <= stb_d;
            stb_c_q <= !stb_d;
        end
    end

    // Data words update at each period start
    // Samples made while gated still move through and are simply
    // not strobed, so the receiver never sees them again
    always_ff @(posedge clk_i) begin
        if (srst) begin
            a_t_q <= CODE_ZERO;
            a_c_q <= ~CODE_ZERO;
            b_t_q <= CODE_ZERO;
            b_c_q <= ~CODE_ZERO;
            ov_t_q <= 1'b0;
            ov_c_q <= 1'b1;
        end else if (ce_i && tick) begin // Words move on while gated
            if (full) begin // Slot was written 74 periods ago
                a_t_q <= pipe_mem[wptr_q][2*W-1:W];
                a_c_q <= ~pipe_mem[wptr_q][2*W-1:W];
                b_t_q <= pipe_mem[wptr_q][W-1:0];
                b_c_q <= ~pipe_mem[wptr_q][W-1:0];
                ov_t_q <= pipe_mem[wptr_q][2*W];
                ov_c_q <= !pipe_mem[wptr_q][2*W];
            end else begin // Line still filling: midscale, no flag
                a_t_q <= CODE_ZERO;
                a_c_q <= ~CODE_ZERO;
                b_t_q <= CODE_ZERO;
                b_c_q <= ~CODE_ZERO;
                ov_t_q <= 1'b0;
                ov_c_q <= 1'b1;
            end
        end
    end

    // Pins straight from flops
    assign link.chan_a_word_t = a_t_q;
    assign link.chan_a_word_c = a_c_q;
    assign link.chan_b_word_t = b_t_q;
    assign link.chan_b_word_c = b_c_q;
    assign link.chan_a_strobe_t = stb_t_q;
    assign link.chan_a_strobe_c = stb_c_q;
    assign link.chan_b_strobe_t = stb_t_q;
    assign link.chan_b_strobe_c = stb_c_q;
    assign link.overrange_flag_t = ov_t_q;
    assign link.overrange_flag_c = ov_c_q;

endmodule : dcap_dev
`default_nettype wire

// [tb/dcap_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module dcap_asserts
    import dcap_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic rstn_i, // Reset, active low
    input wire logic strobe_gate_in, // Gate toward device
    input wire logic dev_rst_n, // Device reset, active low
    input wire logic [W-1:0] chan_a_word_t, // Channel A word, true
    input wire logic [W-1:0] chan_a_word_c, // Channel A word, complement
    input wire logic [W-1:0] chan_b_word_t, // Channel B word, true
    input wire logic [W-1:0] chan_b_word_c, // Channel B word, complement
    input wire logic chan_a_strobe_t, // Channel A strobe, true
    input wire logic chan_a_strobe_c, // Channel A strobe, complement
    input wire logic chan_b_strobe_t, // Channel B strobe, true
    input wire logic chan_b_strobe_c, // Channel B strobe, complement
    input wire logic overrange_flag_t, // Overrange, true
    input wire logic overrange_flag_c // Overrange, complement
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    logic [7:0] rst_low_q; // Consecutive low cycles of device reset
    // Width counter; a plain repetition would need twenty copies
    always_ff @(posedge clk_i) begin
        if (!rstn_i || dev_rst_n) begin
            rst_low_q <= 8'h00;
        end else begin
            rst_low_q <= rst_low_q + 8'h01;
        end
    end
    AST_STB_PAIR: assert property ((chan_a_strobe_c != chan_a_strobe_t) && (chan_b_strobe_c != chan_b_strobe_t))
        else $error("strobe pair not complementary");
    AST_WORD_PAIR: assert property ((chan_a_word_c == ~chan_a_word_t) && (chan_b_word_c == ~chan_b_word_t))
        else $error("data word pair not complementary");
    AST_OVR_PAIR: assert property (overrange_flag_c != overrange_flag_t)
        else $error("overrange pair not complementary");
    AST_AB_TOGETHER: assert property (chan_a_strobe_t == chan_b_strobe_t)
        else $error("channel strobes differ");
    AST_LOW_SPAN: assert property ($fell(chan_a_strobe_t) |-> !chan_a_strobe_t [*4])
        else $error("strobe low span too short");
    AST_GATE_STOP: assert property (!strobe_gate_in [*4] |-> !chan_a_strobe_t)
        else $error("strobe running while gated");
    AST_GATE_HOLD: assert property ($fell(strobe_gate_in) |=> !strobe_gate_in)
        else $error("gate low pulse too short");
    AST_RST_WIDTH: assert property ($rose(dev_rst_n) |-> rst_low_q >= RST_MIN_CYC)
        else $error("device reset pulse too short");
    AST_WORD_HOLD: assert property (chan_a_strobe_t && $past(chan_a_strobe_t)
        |-> $stable(chan_a_word_t) && $stable(chan_b_word_t))
        else $error("data changed under strobe");
endmodule : dcap_asserts
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dcap_pkg::*;
    localparam int SU = 50; // Shortened start-up wait
    logic clk_i; // System clock
    logic rstn_i; // Reset, active low
    logic [7:0] addr_i; // Register address
    logic [31:0] wdata_i; // Write data
    logic we_i; // Write strobe
    logic re_i; // Read strobe
    logic [31:0] rdata_o; // Read data
    logic irq_o; // Interrupt level
    logic signed [IN_W-1:0] ana_a_i; // Channel A level
    logic signed [IN_W-1:0] ana_b_i; // Channel B level
    int mismatches; // Failed comparisons
    int checks; // All comparisons
    int n; // Cycle counter
    logic hit; // Strobe seen
    logic signed [IN_W-1:0] lvl_tab [5] = '{14'sh0bb8, 14'sh0000, 14'sh3448, 14'sh07ff, 14'sh3800}; // Levels
    logic [W-1:0] code_tab [5] = '{12'h7ff, 12'h000, 12'h800, 12'h7ff, 12'h800}; // Expected codes
    logic ovr_tab [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0}; // Expected overrange
    dcap_if link ();
    dcap_dev #(.STARTUP_CYCLES(SU)) i_dcap_dev (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
        .ana_a_i(ana_a_i), .ana_b_i(ana_b_i), .link(link));
    dcap_cap #(.STARTUP_CYCLES(SU)) i_dcap_cap (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1), .addr_i(addr_i),
        .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .irq_o(irq_o), .link(link));
    dcap_asserts i_dcap_asserts (.clk_i(clk_i), .rstn_i(rstn_i), .strobe_gate_in(link.strobe_gate_in),
        .dev_rst_n(link.dev_rst_n), .chan_a_word_t(link.chan_a_word_t), .chan_a_word_c(link.chan_a_word_c),
        .chan_b_word_t(link.chan_b_word_t), .chan_b_word_c(link.chan_b_word_c),
        .chan_a_strobe_t(link.chan_a_strobe_t), .chan_a_strobe_c(link.chan_a_strobe_c),
        .chan_b_strobe_t(link.chan_b_strobe_t), .chan_b_strobe_c(link.chan_b_strobe_c),
        .overrange_flag_t(link.overrange_flag_t), .overrange_flag_c(link.overrange_flag_c));
    // Clock, 10 ns period
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask : wr
    // Read, data taken in the following cycle only
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk = 32'hffffffff);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        @(posedge clk_i);
        chk(rdata_o & msk, exp);
    endtask : rd
    // Bounded wait for a strobe pulse
    task automatic wait_stb(input int lim);
        hit = 1'b0;
        for (int i = 0; i < lim && !hit; i++) begin
            @(posedge clk_i);
            hit = (link.chan_a_strobe_t === 1'b1);
        end
    endtask : wait_stb
    // Single exit point of the run
    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up
    // Watchdog, well above the expected run of about 3900 cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        wrap_up();
    end
    // Main sequence
    initial begin
        rstn_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 32'h0;
        we_i = 1'b0;
        re_i = 1'b0;
        ana_a_i = 14'sh0123;
        ana_b_i = 14'sh3fff;
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(REG_CTRL, 32'h1);
        rd(REG_MASK, 32'h0);
        rd(8'hf0, 32'h0);
        wait_stb(SU + LATENCY * SAMPLE_DIV + 100);
        chk(hit, 1'b1);
        repeat (12) @(posedge clk_i);
        rd({BUF_A_SEL, 6'h00}, 32'h123);
        rd({BUF_B_SEL, 6'h00}, 32'hfff);
        rd(REG_STAT, 32'h9);
        wr(REG_MASK, 32'h1);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b1);
        // Coding and latency, input changed one clock into a period
        for (int k = 0; k < 5; k++) begin
            while (link.chan_a_strobe_t === 1'b1) @(posedge clk_i);
            while (link.chan_a_strobe_t !== 1'b1) @(posedge clk_i);
            ana_a_i <= lvl_tab[k];
            n = 0;
            while (link.chan_a_word_t !== code_tab[k] && n < 700) begin
                @(posedge clk_i);
                n++;
            end
            chk(link.chan_a_word_t, code_tab[k]);
            // Level set one clock into a period, sampled at its last clock,
            // launched 74 periods later and seen one clock after launch
            chk(n, LATENCY * SAMPLE_DIV + SAMPLE_DIV);
            repeat (8) @(posedge clk_i);
            chk(link.overrange_flag_t, ovr_tab[k]);
        end
        chk(link.chan_b_word_t, 12'hfff);
        // Many captures so far, some flagged, buffer A has wrapped
        rd(REG_STAT, 32'hf);
        // Gate low: no strobes, nothing captured
        wr(REG_CTRL, 32'h0);
        // Long enough for a last short pulse to reach the capture end
        repeat (12) @(posedge clk_i);
        wr(REG_STAT, 32'hf);
        n = 0;
        repeat (40) begin
            @(posedge clk_i);
            if (link.chan_a_strobe_t !== 1'b0) n++;
        end
        chk(n, 0);
        chk(irq_o, 1'b0);
        wr(REG_CTRL, 32'h1);
        wait_stb(20);
        chk(hit, 1'b1);
        repeat (12) @(posedge clk_i);
        chk(irq_o, 1'b1);
        wr(REG_MASK, 32'h0);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b0);
        // Device reset pulse through the command register
        wr(REG_CMD, 32'h1);
        rd(REG_INFO, 32'h0, 32'h1);
        repeat (25) @(posedge clk_i);
        rd(REG_INFO, 32'h1, 32'h1);
        repeat (20) @(posedge clk_i);
        chk(link.chan_a_strobe_t, 1'b0);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
